//--- logic/eaf_pkg.sv
// constants, state types and the crc step for the address filter block
// assumes one 100 MHz core clock; all users import the whole package
package eaf_pkg;

  localparam int          ADDR_W       = 48;
  localparam int          CMD_W        = 4;
  localparam int          CSR_W        = 8;
  localparam int          RB_AW        = 11;
  localparam int          FIFO_W       = 1 + RB_AW + 8;
  localparam int          FIFO_DEPTH   = 8;
  localparam int          GROUP_DEPTH  = 8;

  localparam logic [3:0]  CMD_RESET    = 4'h0;
  localparam logic [3:0]  CMD_LOOP_ON  = 4'h1;
  localparam logic [3:0]  CMD_LOOP_OFF = 4'h2;
  localparam logic [3:0]  CMD_SEND     = 4'h3;
  localparam logic [3:0]  CMD_RBUF     = 4'h4;
  localparam logic [3:0]  CMD_LD_GRP   = 4'h5;
  localparam logic [3:0]  CMD_DL_GRP   = 4'h6;
  localparam logic [3:0]  CMD_LD_PHYS  = 4'h7;
  localparam logic [3:0]  CMD_DL_PHYS  = 4'h8;
  localparam logic [3:0]  CMD_SA_OFF   = 4'h9;
  localparam logic [3:0]  CMD_SA_ON    = 4'hA;

  localparam int          CSR_CMD_DONE = 7;
  localparam int          CSR_RX_DONE  = 5;
  localparam int          CSR_ERR      = 0;
  localparam logic [7:0]  CSR_RESET    = 8'h00;

  localparam logic [10:0] RB_STAT0     = 11'h000;
  localparam logic [10:0] RB_STAT1     = 11'h001;
  localparam logic [10:0] RB_SIZE_LO   = 11'h002;
  localparam logic [10:0] RB_SIZE_HI   = 11'h003;
  localparam logic [10:0] RB_DEST      = 11'h004;
  localparam logic [10:0] RB_LAST      = 11'h7FF;
  localparam int          STAT_CRC     = 0;
  localparam int          STAT_OVF     = 1;

  localparam logic [10:0] TX_SA_FIRST  = 11'h006;
  localparam logic [10:0] TX_SA_LAST   = 11'h00B;
  localparam logic [10:0] DEST_LAST    = 11'h005;
  localparam logic [2:0]  DEST_K_LAST  = 3'h5;
  localparam int          MCAST_BIT    = 40;
  localparam logic [47:0] BCAST        = 48'hFFFFFFFFFFFF;
  localparam int          MIN_PHYS_VER = 2;

  localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY     = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE  = 32'hDEBB20E3;

  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_FCS} eaf_tx_state_type;
  typedef enum logic [2:0] {RX_DEST, RX_DECIDE, RX_WDEST, RX_BODY, RX_DROP,
                            RX_STAT} eaf_rx_state_type;

  function automatic logic [31:0] eaf_crc_byte(input logic [31:0] c,
                                               input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

//--- logic/eaf_fifo.sv
// small first-word-fall-through fifo between receive filter and buffer
// assumes one clock; the writer side checks in_ready before pushing
module eaf_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } eaf_fifo_state_type;

  eaf_fifo_state_type s_reg;
  eaf_fifo_state_type s_next;
  logic               push;
  logic               pop;

  assign in_ready  = s_reg.cnt != (PW + 1)'(DEPTH);
  assign out_valid = s_reg.cnt != '0;
  assign out_data  = s_reg.mem[s_reg.rp];

  always_comb begin
    s_next = s_reg;
    push   = in_valid && in_ready;
    pop    = out_valid && out_ready;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp            = PW'((s_reg.wp + 1'b1) % DEPTH);
    end
    if (pop) begin
      s_next.rp = PW'((s_reg.rp + 1'b1) % DEPTH);
    end
    s_next.cnt = s_reg.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

//--- logic/eaf_group_table.sv
// table of loaded multicast group addresses with a registered match
// assumes loads and deletes arrive as one-cycle strobes on the core clock
module eaf_group_table
  import eaf_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       clear,
  input  wire logic                       load,
  input  wire logic                       del,
  input  wire logic [eaf_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic                       look_valid,
  input  wire logic [eaf_pkg::ADDR_W-1:0] look_addr,
  output logic                            match_reg
);
  typedef struct packed {
    logic [GROUP_DEPTH-1:0]             vld;
    logic [GROUP_DEPTH-1:0][ADDR_W-1:0] addr;
    logic                               match;
  } eaf_grp_state_type;

  eaf_grp_state_type      s_reg;
  eaf_grp_state_type      s_next;
  logic [GROUP_DEPTH-1:0] wr_hit;
  logic [GROUP_DEPTH-1:0] look_hit;
  logic                   placed;

  for (genvar i = 0; i < GROUP_DEPTH; i++) begin : g_ent
    assign wr_hit[i]   = s_reg.vld[i] && s_reg.addr[i] == wr_addr;
    assign look_hit[i] = s_reg.vld[i] && s_reg.addr[i] == look_addr;
  end

  assign match_reg = s_reg.match;

  // a full table silently ignores a further load
  always_comb begin
    s_next = s_reg;
    placed = |wr_hit;
    if (look_valid) begin
      s_next.match = |look_hit;
    end
    for (int i = 0; i < GROUP_DEPTH; i++) begin
      if (load && !placed && !s_reg.vld[i]) begin
        s_next.vld[i]  = 1'b1;
        s_next.addr[i] = wr_addr;
        placed         = 1'b1;
      end
      if (del && wr_hit[i]) begin
        s_next.vld[i] = 1'b0;
      end
    end
    if (clear) begin
      s_next.vld = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

//--- logic/eaf_top.sv
// address filter, source insertion and loopback of the ethernet controller
// assumes host command port, byte streams and buffer port on core_clk
//
// Operation
// [R1] loopback command sends transmit frames to receiver
// [R2] broadcast destination frames are always accepted
// [R3] wrong individual destination frames are discarded
// [R4] load group command adds multicast filter address
// [R5] unloaded multicast destinations are discarded silently
// [R6] delete group command removes multicast address
// [R7] load physical command replaces station address
// [R8] delete physical command drops replacement address
// [R9] inhibited insertion keeps source; crc then fails
// [R10] enabled insertion overwrites source with station
// [R11] clean command completion shows octal 200
// [R12] clean reception alone shows octal 40
// [R13] buffer command plus reception shows octal 240
// [R14] buffer holds status, size, destination, source
// [R15] frame check bytes end the buffered frame
// [R16] first byte bit zero marks multicast
module eaf_top
  import eaf_pkg::*;
#(
  parameter logic [47:0] STATION_ADDR = 48'h020000000001,
  parameter int          HW_VERSION   = 2
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       cmd_valid,
  input  wire logic [eaf_pkg::CMD_W-1:0]  cmd_code,
  input  wire logic [eaf_pkg::ADDR_W-1:0] cmd_addr,
  output logic                            cmd_ready,
  output logic [eaf_pkg::CSR_W-1:0]       csr,
  input  wire logic                       csr_rx_ack,
  output logic                            loop_mode,
  input  wire logic                       tx_valid,
  input  wire logic [7:0]                 tx_data,
  input  wire logic                       tx_last,
  output logic                            tx_ready,
  output logic                            line_tx_valid,
  output logic [7:0]                      line_tx_data,
  output logic                            line_tx_last,
  input  wire logic                       line_tx_ready,
  input  wire logic                       line_rx_valid,
  input  wire logic [7:0]                 line_rx_data,
  input  wire logic                       line_rx_last,
  output logic                            line_rx_ready,
  output logic                            rbuf_we,
  output logic [eaf_pkg::RB_AW-1:0]       rbuf_addr,
  output logic [7:0]                      rbuf_data,
  input  wire logic                       rbuf_ready
);
  import eaf_pkg::*;

  typedef struct packed {
    logic [CSR_W-1:0]  csr;
    logic              loop;
    logic              sa_inhibit;
    logic              phys_vld;
    logic [ADDR_W-1:0] phys;
    logic              rbuf_avail;
    logic              cmd_ready;
    eaf_tx_state_type  tx_st;
    logic [10:0]       tx_idx;
    logic [31:0]       tx_crc;
    logic [1:0]        tx_fcs;
    logic              tx_ready;
    logic              lt_valid;
    logic [7:0]        lt_data;
    logic              lt_last;
    logic              line_tx_valid;
    eaf_rx_state_type  rx_st;
    logic              rx_rdy;
    logic              line_rx_ready;
    logic [10:0]       rx_idx;
    logic [ADDR_W-1:0] rx_dest;
    logic [31:0]       rx_crc;
    logic [10:0]       rx_wptr;
    logic              rx_ovf;
    logic              rx_crc_err;
    logic [2:0]        rx_k;
    logic              rbuf_we;
    logic [10:0]       rbuf_addr;
    logic [7:0]        rbuf_data;
    logic              rbuf_last;
  } eaf_top_state_type;

  eaf_top_state_type s_reg;
  eaf_top_state_type s_next;

  logic [ADDR_W-1:0] station;
  logic              cmd_take;
  logic              cmd_done;
  logic              cmd_err;
  logic              grp_load;
  logic              grp_del;
  logic              grp_clear;
  logic              grp_match;
  logic              look_valid;
  logic [ADDR_W-1:0] look_addr;
  logic              in_sa;
  logic [7:0]        sa_byte;
  logic [7:0]        tx_byte;
  logic [7:0]        crc_src;
  logic              tx_take;
  logic              lt_pop;
  logic              rx_take;
  logic [7:0]        src_data;
  logic              src_last;
  logic [31:0]       crc_base;
  logic [31:0]       rx_crc_nx;
  logic              accept;
  logic              push;
  logic [FIFO_W-1:0] push_data;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [FIFO_W-1:0] fifo_out_data;
  logic              fifo_out_ready;
  logic              wr_accept;
  logic              wr_done;

  eaf_group_table u_grp (
    .clk        (core_clk),
    .rst        (rst),
    .clear      (grp_clear),
    .load       (grp_load),
    .del        (grp_del),
    .wr_addr    (cmd_addr),
    .look_valid (look_valid),
    .look_addr  (look_addr),
    .match_reg  (grp_match)
  );

  // the fifo absorbs buffer-port stalls; when full the receiver stalls
  eaf_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_data   (push_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready)
  );

  assign cmd_ready     = s_reg.cmd_ready;
  assign csr           = s_reg.csr;
  assign loop_mode     = s_reg.loop;
  assign tx_ready      = s_reg.tx_ready;
  assign line_tx_valid = s_reg.line_tx_valid;
  assign line_tx_data  = s_reg.lt_data;
  assign line_tx_last  = s_reg.lt_last;
  assign line_rx_ready = s_reg.line_rx_ready;
  assign rbuf_we       = s_reg.rbuf_we;
  assign rbuf_addr     = s_reg.rbuf_addr;
  assign rbuf_data     = s_reg.rbuf_data;

  always_comb begin
    s_next    = s_reg;
    station   = s_reg.phys_vld ? s_reg.phys : STATION_ADDR; // [R7] [R8]
    cmd_take  = cmd_valid && s_reg.cmd_ready;
    cmd_done  = 1'b0;
    cmd_err   = 1'b0;
    grp_load  = 1'b0;
    grp_del   = 1'b0;
    grp_clear = 1'b0;
    accept    = 1'b0;

    // command decode
    if (cmd_take) begin
      s_next.csr[CSR_CMD_DONE] = 1'b0;
      s_next.csr[CSR_ERR]      = 1'b0;
      cmd_done                 = cmd_code != CMD_SEND;
      unique case (cmd_code)
        CMD_RESET: begin
          s_next.loop       = 1'b0;
          s_next.sa_inhibit = 1'b0;
          s_next.phys_vld   = 1'b0;
          s_next.rbuf_avail = 1'b0;
          grp_clear         = 1'b1;
        end
        CMD_LOOP_ON:  s_next.loop = 1'b1; // [R1]
        CMD_LOOP_OFF: s_next.loop = 1'b0;
        CMD_SEND: begin
          s_next.tx_st  = TX_DATA;
          s_next.tx_idx = '0;
          s_next.tx_crc = CRC_INIT;
        end
        CMD_RBUF: s_next.rbuf_avail = 1'b1; // [R13]
        CMD_LD_GRP: begin
          grp_load = cmd_addr[MCAST_BIT]; // [R4]
          cmd_err  = !cmd_addr[MCAST_BIT];
        end
        CMD_DL_GRP: grp_del = 1'b1; // [R6]
        CMD_LD_PHYS: begin
          // older hardware has no replaceable station address
          if (HW_VERSION >= MIN_PHYS_VER) begin
            s_next.phys_vld = 1'b1; // [R7]
            s_next.phys     = cmd_addr;
          end else begin
            cmd_err = 1'b1;
          end
        end
        CMD_DL_PHYS: s_next.phys_vld = 1'b0; // [R8]
        CMD_SA_OFF:  s_next.sa_inhibit = 1'b1; // [R9]
        CMD_SA_ON:   s_next.sa_inhibit = 1'b0; // [R10]
        default:     cmd_err = 1'b1;
      endcase
    end

    // receive source: own transmitter in loopback, else the line
    if (s_reg.loop) begin
      rx_take  = s_reg.rx_rdy && s_reg.lt_valid; // [R1]
      src_data = s_reg.lt_data;
      src_last = s_reg.lt_last;
    end else begin
      rx_take  = s_reg.line_rx_ready && line_rx_valid;
      src_data = line_rx_data;
      src_last = line_rx_last;
    end

    // transmit path
    in_sa   = s_reg.tx_idx >= TX_SA_FIRST && s_reg.tx_idx <= TX_SA_LAST;
    sa_byte = 8'(station >> {3'(TX_SA_LAST - s_reg.tx_idx), 3'b000});
    tx_byte = (in_sa && !s_reg.sa_inhibit) ? sa_byte : tx_data; // [R10] [R9]
    // fcs always covers the station source, so a kept host source fails
    crc_src = in_sa ? sa_byte : tx_data; // [R9]
    tx_take = s_reg.tx_ready && tx_valid;
    lt_pop  = s_reg.loop ? rx_take
                         : (s_reg.line_tx_valid && line_tx_ready); // [R1]
    if (lt_pop) begin
      s_next.lt_valid = 1'b0;
    end
    unique case (s_reg.tx_st)
      TX_IDLE: begin
      end
      TX_DATA: begin
        if (tx_take) begin
          s_next.lt_valid = 1'b1;
          s_next.lt_data  = tx_byte;
          s_next.lt_last  = 1'b0;
          s_next.tx_crc   = eaf_crc_byte(s_reg.tx_crc, crc_src);
          s_next.tx_idx   = s_reg.tx_idx + 11'h001;
          if (tx_last) begin
            s_next.tx_st  = TX_FCS;
            s_next.tx_fcs = '0;
          end
        end
      end
      TX_FCS: begin
        if (!s_next.lt_valid) begin
          s_next.lt_valid = 1'b1;
          s_next.lt_data  = 8'(~(s_reg.tx_crc >> {s_reg.tx_fcs, 3'b000}));
          s_next.lt_last  = s_reg.tx_fcs == 2'h3;
          s_next.tx_fcs   = s_reg.tx_fcs + 2'h1;
          if (s_reg.tx_fcs == 2'h3) begin
            s_next.tx_st = TX_IDLE;
            cmd_done     = 1'b1; // [R11]
          end
        end
      end
    endcase
    // one byte in flight at a time keeps ready a plain flop
    s_next.tx_ready      = s_next.tx_st == TX_DATA && !s_next.lt_valid
                           && !tx_take;
    s_next.line_tx_valid = s_next.lt_valid && !s_next.loop; // [R1]

    // receive filter
    crc_base   = (s_reg.rx_st == RX_DEST && s_reg.rx_idx == '0)
                 ? CRC_INIT : s_reg.rx_crc;
    rx_crc_nx  = eaf_crc_byte(crc_base, src_data);
    look_valid = 1'b0;
    look_addr  = {s_reg.rx_dest[39:0], src_data};
    push       = 1'b0;
    push_data  = '0;
    unique case (s_reg.rx_st)
      RX_DEST: begin
        if (rx_take) begin
          s_next.rx_dest = look_addr;
          s_next.rx_crc  = rx_crc_nx;
          s_next.rx_idx  = s_reg.rx_idx + 11'h001;
          if (src_last) begin
            s_next.rx_idx = '0;
          end else if (s_reg.rx_idx == DEST_LAST) begin
            look_valid   = 1'b1; // [R4]
            s_next.rx_st = RX_DECIDE;
          end
        end
      end
      RX_DECIDE: begin
        if (s_reg.rx_dest == BCAST) begin
          accept = 1'b1; // [R2]
        end else if (s_reg.rx_dest[MCAST_BIT]) begin // [R16]
          accept = grp_match; // [R4] [R5] [R6]
        end else begin
          accept = s_reg.rx_dest == station; // [R3] [R7] [R8]
        end
        if (accept && s_reg.rbuf_avail) begin
          s_next.rbuf_avail = cmd_take && cmd_code == CMD_RBUF;
          s_next.rx_st      = RX_WDEST;
          s_next.rx_k       = '0;
          s_next.rx_wptr    = RB_DEST; // [R14]
          s_next.rx_ovf     = 1'b0;
        end else begin
          s_next.rx_st = RX_DROP; // [R3] [R5]
        end
      end
      RX_WDEST: begin
        if (fifo_in_ready) begin
          push           = 1'b1;
          push_data      = {1'b0, s_reg.rx_wptr,
                            8'(s_reg.rx_dest >>
                               {3'(DEST_K_LAST - s_reg.rx_k), 3'b000})};
          s_next.rx_wptr = s_reg.rx_wptr + 11'h001;
          s_next.rx_k    = s_reg.rx_k + 3'h1;
          if (s_reg.rx_k == DEST_K_LAST) begin
            s_next.rx_st = RX_BODY;
          end
        end
      end
      RX_BODY: begin
        if (rx_take) begin
          s_next.rx_crc = rx_crc_nx;
          s_next.rx_idx = s_reg.rx_idx + 11'h001;
          // a frame longer than the buffer is cut and flagged
          if (s_reg.rx_wptr == RB_LAST) begin
            s_next.rx_ovf = 1'b1;
          end else begin
            push           = 1'b1; // [R14] [R15]
            push_data      = {1'b0, s_reg.rx_wptr, src_data};
            s_next.rx_wptr = s_reg.rx_wptr + 11'h001;
          end
          if (src_last) begin
            s_next.rx_st      = RX_STAT;
            s_next.rx_k       = '0;
            s_next.rx_crc_err = rx_crc_nx != CRC_RESIDUE; // [R9]
          end
        end
      end
      RX_STAT: begin
        if (fifo_in_ready) begin
          push = 1'b1; // [R14]
          unique case (s_reg.rx_k[1:0])
            2'h0: push_data = {1'b0, RB_STAT0, 6'h00, s_reg.rx_ovf,
                               s_reg.rx_crc_err};
            2'h1: push_data = {1'b0, RB_STAT1, 8'h00};
            2'h2: push_data = {1'b0, RB_SIZE_LO, s_reg.rx_idx[7:0]};
            2'h3: push_data = {1'b1, RB_SIZE_HI, 5'h00, s_reg.rx_idx[10:8]};
          endcase
          s_next.rx_k = s_reg.rx_k + 3'h1;
          if (s_reg.rx_k[1:0] == 2'h3) begin
            s_next.rx_st  = RX_DEST;
            s_next.rx_idx = '0;
          end
        end
      end
      RX_DROP: begin
        if (rx_take && src_last) begin
          s_next.rx_st  = RX_DEST;
          s_next.rx_idx = '0;
        end
      end
      default: s_next.rx_st = RX_DEST;
    endcase
    // no push in the ready cycle guarantees fifo room on the next take
    s_next.rx_rdy        = (s_next.rx_st == RX_DEST
                            || s_next.rx_st == RX_BODY
                            || s_next.rx_st == RX_DROP)
                           && fifo_in_ready && !push;
    s_next.line_rx_ready = s_next.rx_rdy && !s_next.loop;

    // host buffer writer
    wr_accept      = s_reg.rbuf_we && rbuf_ready;
    fifo_out_ready = !s_reg.rbuf_we || rbuf_ready;
    wr_done        = wr_accept && s_reg.rbuf_last;
    if (wr_accept) begin
      s_next.rbuf_we = 1'b0;
    end
    if (fifo_out_valid && fifo_out_ready) begin
      s_next.rbuf_we   = 1'b1;
      s_next.rbuf_last = fifo_out_data[FIFO_W-1];
      s_next.rbuf_addr = fifo_out_data[FIFO_W-2:8];
      s_next.rbuf_data = fifo_out_data[7:0];
    end

    // status: hardware set wins over host clear
    if (csr_rx_ack) begin
      s_next.csr[CSR_RX_DONE] = 1'b0;
    end
    if (wr_done) begin
      s_next.csr[CSR_RX_DONE] = 1'b1; // [R12] [R13]
    end
    if (cmd_done) begin
      s_next.csr[CSR_CMD_DONE] = 1'b1; // [R11] [R13]
    end
    if (cmd_err) begin
      s_next.csr[CSR_ERR] = 1'b1;
    end
    s_next.cmd_ready = s_next.tx_st == TX_IDLE && !cmd_take;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg     <= '0;
      s_reg.csr <= CSR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

//--- verif/eaf_buf_model.sv
// receive buffer memory standing at the block's buffer write port
// assumes held writes; stalls every other cycle to press the fifo
module eaf_buf_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        rbuf_we,
  input  wire logic [10:0] rbuf_addr,
  input  wire logic [7:0]  rbuf_data,
  output logic             rbuf_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:2047];
  int         n_wr = 0;
  always_ff @(posedge core_clk) begin
    rbuf_ready <= !rst && !rbuf_ready;
    if (rbuf_we && rbuf_ready) begin
      mem[rbuf_addr] <= rbuf_data;
      n_wr <= n_wr + 1;
    end
  end
endmodule

//--- verif/eaf_top_sva.sv
// port checker for the address filter top
// assumes one clock domain with synchronous reset
module eaf_top_sva
  import eaf_pkg::*;
(
  input wire logic                       core_clk,
  input wire logic                       rst,
  input wire logic                       cmd_valid,
  input wire logic [eaf_pkg::CMD_W-1:0]  cmd_code,
  input wire logic [eaf_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic                       cmd_ready,
  input wire logic [eaf_pkg::CSR_W-1:0]  csr,
  input wire logic                       loop_mode,
  input wire logic                       line_tx_valid,
  input wire logic                       line_rx_ready,
  input wire logic                       rbuf_we,
  input wire logic [eaf_pkg::RB_AW-1:0]  rbuf_addr,
  input wire logic [7:0]                 rbuf_data,
  input wire logic                       rbuf_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic take;
  assign take = cmd_valid && cmd_ready;
  chk_loop_quiet: assert property (loop_mode |-> !line_tx_valid
    && !line_rx_ready) else $error("line used in loopback");
  chk_loop_enter: assert property (take && cmd_code == CMD_LOOP_ON
    |=> loop_mode && (csr & 8'hDF) == 8'h80) else $error("no loopback");
  chk_cmd_done: assert property (take && cmd_code == CMD_RBUF
    |=> (csr & 8'hDF) == 8'h80) else $error("bad command done");
  chk_send_clear: assert property (take && cmd_code == CMD_SEND
    |=> !csr[7] && !csr[0]) else $error("done not cleared");
  chk_take_gap: assert property (take |=> !cmd_ready)
    else $error("ready after take");
  chk_bad_group: assert property (take && cmd_code == CMD_LD_GRP
    && !cmd_addr[MCAST_BIT] |=> csr[7] && csr[0])
    else $error("unicast group not refused");
  chk_rx_done: assert property ($rose(csr[5]) |-> $past(rbuf_we
    && rbuf_ready && rbuf_addr == RB_SIZE_HI)) else $error("early rx");
  chk_wr_hold: assert property (rbuf_we && !rbuf_ready |=> rbuf_we
    && $stable(rbuf_addr) && $stable(rbuf_data)) else $error("write lost");
  cover property ($rose(csr[5]));
  cover property (take && cmd_code == CMD_LD_GRP);
  cover property (rbuf_we && !rbuf_ready);
endmodule

bind eaf_top eaf_top_sva u_sva (.core_clk(core_clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
  .cmd_ready(cmd_ready), .csr(csr), .loop_mode(loop_mode),
  .line_tx_valid(line_tx_valid), .line_rx_ready(line_rx_ready),
  .rbuf_we(rbuf_we), .rbuf_addr(rbuf_addr), .rbuf_data(rbuf_data),
  .rbuf_ready(rbuf_ready));

//--- verif/test_eaf_top.sv
// loopback bench: commands, frames and buffer checks for the filter
// assumes the line side idles, so its inputs are tied off
module test_eaf_top
  import eaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] ST = 48'h020000000001;
  localparam logic [47:0] B1 = 48'h020000000002;
  localparam logic [47:0] G1 = 48'h030000000002;
  localparam logic [47:0] G0 = 48'h030000000001;
  logic core_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, csr_rx_ack = 1'b0;
  logic tx_valid = 1'b0, tx_last = 1'b0, last_rx = 1'b0;
  logic [3:0] cmd_code = 4'h0;
  logic [47:0] cmd_addr = '0;
  logic [7:0] tx_data = 8'h00, csr, rbuf_data;
  logic [10:0] rbuf_addr;
  logic cmd_ready, loop_mode, tx_ready, rbuf_we, rbuf_ready;
  int n_fail = 0, checked = 0, cyc = 0;

  eaf_top #(.STATION_ADDR(ST)) DUT (.core_clk(core_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
    .cmd_ready(cmd_ready), .csr(csr), .csr_rx_ack(csr_rx_ack),
    .loop_mode(loop_mode), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .line_tx_valid(),
    .line_tx_data(), .line_tx_last(), .line_tx_ready(1'b1),
    .line_rx_valid(1'b0), .line_rx_data(8'h00), .line_rx_last(1'b0),
    .line_rx_ready(), .rbuf_we(rbuf_we), .rbuf_addr(rbuf_addr),
    .rbuf_data(rbuf_data), .rbuf_ready(rbuf_ready));
  eaf_buf_model u_buf (.core_clk(core_clk), .rst(rst), .rbuf_we(rbuf_we),
    .rbuf_addr(rbuf_addr), .rbuf_data(rbuf_data), .rbuf_ready(rbuf_ready));

  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic print_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ceiling far above the 2000 or so cycles needed
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict;
    end
  end
  task automatic cmp8(input logic [7:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic do_cmd(input logic [3:0] c, input logic [47:0] a);
    tick;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_addr = a;
    while (cmd_ready !== 1'b1) tick;
    tick;
    cmd_valid = 1'b0;
  endtask
  // bounded wait; a missing flag shows up in the next compare
  task automatic wait_bit(input int b);
    for (int i = 0; i < 200 && csr[b] !== 1'b1; i++) tick;
  endtask
  task automatic run_cmd(input logic [3:0] c, input logic [47:0] a,
                         input logic [7:0] exp);
    do_cmd(c, a);
    wait_bit(7);
    cmp8(csr & 8'hDF, exp, "cmd csr");
  endtask
  task automatic frame(input logic [47:0] d, s, es, input logic rx, ce);
    int n0;
    logic [7:0] b [16];
    n0 = u_buf.n_wr;
    for (int i = 0; i < 6; i++) begin
      b[i] = d[47-8*i -: 8];
      b[i+6] = s[47-8*i -: 8];
    end
    for (int i = 12; i < 16; i++) b[i] = 8'(i * 17);
    run_cmd(CMD_RBUF, '0, 8'h80);
    do_cmd(CMD_SEND, '0);
    cmp8(csr, last_rx ? 8'h20 : 8'h00, "csr in send");
    csr_rx_ack = 1'b1;
    tick;
    csr_rx_ack = 1'b0;
    for (int i = 0; i < 16; i++) begin
      tx_valid = 1'b1;
      tx_data = b[i];
      tx_last = (i == 15);
      while (tx_ready !== 1'b1) tick;
      tick;
    end
    tx_valid = 1'b0;
    tx_last = 1'b0;
    wait_bit(7);
    wait_bit(5);
    cmp8(csr, rx ? 8'hA0 : 8'h80, "csr after frame");
    cmp8(8'(u_buf.n_wr - n0), rx ? 8'h18 : 8'h00, "writes");
    last_rx = rx;
    if (rx) begin
      cmp8(u_buf.mem[2], 8'h14, "size");
      cmp8(u_buf.mem[0] & 8'h01, {7'h00, ce}, "crc flag");
      for (int i = 0; i < 6; i++) begin
        cmp8(u_buf.mem[4+i], b[i], "dest");
        cmp8(u_buf.mem[10+i], es[47-8*i -: 8], "src");
      end
      for (int i = 12; i < 16; i++) cmp8(u_buf.mem[4+i], b[i], "data");
    end
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    run_cmd(CMD_RESET, '0, 8'h80);
    run_cmd(CMD_LOOP_ON, '0, 8'h80);
    cmp8({7'h00, loop_mode}, 8'h01, "loop");
    frame(BCAST, B1, ST, 1'b1, 1'b0);
    frame(B1, ST, ST, 1'b0, 1'b0);
    run_cmd(CMD_LD_GRP, B1, 8'h81);
    run_cmd(CMD_LD_GRP, G1, 8'h80);
    frame(G1, ST, ST, 1'b1, 1'b0);
    frame(G0, ST, ST, 1'b0, 1'b0);
    run_cmd(CMD_DL_GRP, G1, 8'h80);
    frame(G1, ST, ST, 1'b0, 1'b0);
    run_cmd(CMD_LD_PHYS, B1, 8'h80);
    frame(B1, ST, B1, 1'b1, 1'b0);
    run_cmd(CMD_DL_PHYS, '0, 8'h80);
    frame(B1, ST, ST, 1'b0, 1'b0);
    run_cmd(CMD_SA_OFF, '0, 8'h80);
    frame(ST, B1, B1, 1'b1, 1'b1);
    run_cmd(CMD_SA_ON, '0, 8'h80);
    frame(ST, B1, ST, 1'b1, 1'b0);
    run_cmd(CMD_LOOP_OFF, '0, 8'h80);
    frame(ST, B1, ST, 1'b0, 1'b0);
    print_verdict;
  end
endmodule
